// File: rtl/dcxm_regs.svh
// Register map, field positions, reset values and timing counts.
// Assumes inclusion by the word mover and the transfer-mode block only.
`ifndef DCXM_REGS_SVH
`define DCXM_REGS_SVH

// Byte offsets on the register bus
`define DCXM_OFF_CTRL      4'h0
`define DCXM_OFF_COUNT     4'h4
`define DCXM_OFF_STATUS    4'h8
`define DCXM_OFF_IRQ_CLR   4'hC

`define DCXM_AW            4

// Control register fields
`define DCXM_EN_BIT        23
`define DCXM_IE_BIT        22
`define DCXM_MODE_HI       21
`define DCXM_MODE_LO       19

// Status register fields
`define DCXM_ST_DONE_BIT   0
`define DCXM_ST_STOP_BIT   1
`define DCXM_ST_BUSY_BIT   8
`define DCXM_ST_CNT_LO     16

// Reset values
`define DCXM_CTRL_RST      32'h0000_0000
`define DCXM_COUNT_RST     16'h0000

// Cycles taken by one word move (read then store)
`define DCXM_WORD_CYC      2

`endif

// File: rtl/dcxm_pkg.sv
// Types shared by the transfer-mode block and its word mover.
// Assumes the register header supplies all numbers.
package dcxm_pkg;

   typedef enum logic [2:0] {
      DCXM_MODE_BLK_REQ  = 3'h0,
      DCXM_MODE_WORD_REQ = 3'h1,
      DCXM_MODE_LINE_REQ = 3'h2,
      DCXM_MODE_BLK_EN   = 3'h3,
      DCXM_MODE_BLK_ARM  = 3'h4,
      DCXM_MODE_WORD_RUN = 3'h5,
      DCXM_MODE_RSV6     = 3'h6,
      DCXM_MODE_RSV7     = 3'h7
   } dcxm_mode_t;

   // Gray along idle -> wait -> move -> done
   typedef enum logic [1:0] {
      DCXM_ST_IDLE = 2'b00,
      DCXM_ST_WAIT = 2'b01,
      DCXM_ST_MOVE = 2'b11,
      DCXM_ST_DONE = 2'b10
   } dcxm_state_t;

   typedef struct packed {
      logic       en;
      logic       ie;
      dcxm_mode_t mode;
   } dcxm_ctrl_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } dcxm_avl_req_t;

endpackage : dcxm_pkg

// File: rtl/dcxm_word_mover.sv
// Word mover: one word transfer takes a fixed number of cycles.
// Assumes a start pulse only while idle; done pulses once stored.
`timescale 1ns/1ps
`include "dcxm_regs.svh"

module dcxm_word_mover import dcxm_pkg::*; #(
   parameter int unsigned WORD_CYC = `DCXM_WORD_CYC
) (
   input  wire logic clock,
   input  wire logic rst_sync_n,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   // Elaboration check: the down-counter is eight bits wide
   if (WORD_CYC < 1 || WORD_CYC > 255) begin : g_bad_word_cyc
      $error("WORD_CYC out of range");
   end

   logic [7:0] left_q;
   logic [7:0] left_d;
   logic       done_d;

   assign left_d = start ? 8'(WORD_CYC)
                 : (left_q != 8'h00) ? left_q - 8'h01 : 8'h00;
   assign done_d = (left_q == 8'h01);
   assign busy   = (left_q != 8'h00);

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         left_q <= 8'h00;
         done   <= 1'b0;
      end else begin
         left_q <= left_d;
         done   <= done_d;
      end
   end
endmodule // dcxm_word_mover

// File: rtl/dcxm_transfer_modes.sv
// One DMA channel's transfer-mode sequencer with Avalon-MM registers.
// Assumes peripheral requests arrive asynchronously on dma_req.
`timescale 1ns/1ps
`include "dcxm_regs.svh"

module dcxm_transfer_modes import dcxm_pkg::*; #(
   parameter int unsigned CNT_W    = 16,
   parameter int unsigned LINE_LEN = 4
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        dma_req,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   output logic             word_move,
   output logic             block_end
);
   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // Count readback is sixteen bits wide
   if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
      $error("CNT_W must be 1..16");
   end
   // Line counter is eight bits wide
   if (LINE_LEN < 1 || LINE_LEN > 255) begin : g_bad_line_len
      $error("LINE_LEN must be 1..255");
   end

   // ------------------------------------------------------------------
   // Reset release and request synchroniser
   // ------------------------------------------------------------------
   logic       rst_s1_q;
   logic       rst_sync_n;
   logic [2:0] req_sync_q;
   logic       req_level_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_q   <= 1'b1;
         rst_sync_n <= rst_s1_q;
      end
   end

   wire req_agree = (req_sync_q[1] == req_sync_q[2]);
   wire req_rise  = req_agree && req_sync_q[2] && !req_level_q;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         req_sync_q  <= 3'b000;
         req_level_q <= 1'b0;
      end else begin
         req_sync_q  <= {req_sync_q[1:0], dma_req};
         if (req_agree) req_level_q <= req_sync_q[2];
      end
   end

   // ------------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------------
   dcxm_avl_req_t bus;
   logic          ack_q;
   assign bus = '{read: avs_read, write: avs_write,
                  address: avs_address, writedata: avs_writedata};

   // One wait cycle per access; answer on the second edge
   wire acc     = (bus.read || bus.write) && !ack_q;
   wire wr_take = bus.write && ack_q;
   wire wr_ctrl = wr_take && (bus.address == `DCXM_OFF_CTRL);
   wire wr_cnt  = wr_take && (bus.address == `DCXM_OFF_COUNT);
   wire wr_clr  = wr_take && (bus.address == `DCXM_OFF_IRQ_CLR);

   // ------------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------------
   dcxm_ctrl_t       ctrl_q;
   dcxm_ctrl_t       ctrl_d;
   logic [CNT_W-1:0] orig_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [7:0]       line_q;
   logic [7:0]       line_d;
   dcxm_state_t      st_q;
   dcxm_state_t      st_d;
   logic             pend_q;
   logic             pend_d;
   logic [1:0]       sts_q;
   logic             mv_busy;
   logic             mv_done;
   logic             mv_start;

   wire dcxm_mode_t mode = ctrl_q.mode;
   wire per_word  = (mode == DCXM_MODE_WORD_REQ) ||
                    (mode == DCXM_MODE_WORD_RUN);
   wire is_line   = (mode == DCXM_MODE_LINE_REQ);
   wire by_enable = (mode == DCXM_MODE_BLK_EN);
   wire valid_md  = (mode != DCXM_MODE_RSV6) &&
                    (mode != DCXM_MODE_RSV7);
   wire keeps_en  = (mode == DCXM_MODE_BLK_ARM) ||
                    (mode == DCXM_MODE_WORD_RUN);
   wire run_block = (mode == DCXM_MODE_BLK_REQ) ||
                    (mode == DCXM_MODE_BLK_ARM) || by_enable;

   // Last word of the block and last word of a line
   wire cnt_last  = (cnt_q == CNT_W'(1));
   wire line_last = (line_q == 8'h01);
   wire blk_end   = mv_done && cnt_last;

   // Software clear of the enable while the channel is enabled
   wire sw_clear  = wr_ctrl && !bus.writedata[`DCXM_EN_BIT] && ctrl_q.en;

   // State decode
   wire in_idle   = (st_q == DCXM_ST_IDLE);
   wire in_wait   = (st_q == DCXM_ST_WAIT);
   wire in_move   = (st_q == DCXM_ST_MOVE);

   // Request pending: a second request during service is held once.
   // Dropped while idle so a request seen in an unused mode cannot
   // fire a word on the next enable.
   wire pend_drop = in_idle || (in_wait && !by_enable);
   assign pend_d = pend_drop ? 1'b0
                 : (req_rise ? 1'b1 : pend_q);
   wire trigger  = by_enable || req_rise || (per_word && pend_q);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      mv_start = 1'b0;
      case (st_q)
         DCXM_ST_IDLE: begin
            if (ctrl_q.en && valid_md) st_d = DCXM_ST_WAIT;
         end
         DCXM_ST_WAIT: begin
            if (!ctrl_q.en || !valid_md) begin
               st_d = DCXM_ST_IDLE;
            end else if (trigger) begin
               st_d     = DCXM_ST_MOVE;
               mv_start = 1'b1;
            end
         end
         DCXM_ST_MOVE: begin
            if (mv_done) begin
               if (blk_end) begin
                  st_d = DCXM_ST_DONE;
               end else if (!ctrl_q.en) begin
                  st_d = DCXM_ST_IDLE;
               end else if (run_block || (is_line && !line_last)) begin
                  mv_start = 1'b1;
               end else begin
                  st_d = DCXM_ST_WAIT;
               end
            end
         end
         DCXM_ST_DONE: begin
            st_d = (ctrl_q.en && keeps_en) ? DCXM_ST_WAIT
                                           : DCXM_ST_IDLE;
         end
         default: st_d = DCXM_ST_IDLE;
      endcase
   end

   // Counter: one decrement per stored word, reload from the written count on the last word
   assign cnt_d = wr_cnt ? avs_writedata[CNT_W-1:0]
                : blk_end ? orig_q
                : mv_done ? cnt_q - CNT_W'(1)
                : cnt_q;

   assign line_d = (mv_done && (line_last || line_q == 8'h00))
                      ? 8'(LINE_LEN)
                 : mv_done ? line_q - 8'h01
                 : in_idle ? 8'(LINE_LEN) : line_q;

   // Enable clears at block end unless the mode keeps it armed
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d.en   = bus.writedata[`DCXM_EN_BIT];
         ctrl_d.ie   = bus.writedata[`DCXM_IE_BIT];
         ctrl_d.mode = dcxm_mode_t'(
                          bus.writedata[`DCXM_MODE_HI:`DCXM_MODE_LO]);
      end
      if (blk_end && !keeps_en) ctrl_d.en = 1'b0;
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_q <= '0;
         orig_q <= `DCXM_COUNT_RST;
         cnt_q  <= `DCXM_COUNT_RST;
         line_q <= 8'h00;
         st_q   <= DCXM_ST_IDLE;
         pend_q <= 1'b0;
         ack_q  <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_cnt) orig_q <= avs_writedata[CNT_W-1:0];
         cnt_q  <= cnt_d;
         line_q <= line_d;
         st_q   <= st_d;
         pend_q <= pend_d;
         ack_q  <= acc;
      end
   end

   dcxm_word_mover #(
      .WORD_CYC (`DCXM_WORD_CYC)
   ) u_mover (
      .clock      (clock),
      .rst_sync_n (rst_sync_n),
      .start      (mv_start),
      .busy       (mv_busy),
      .done       (mv_done)
   );

   // ------------------------------------------------------------------
   // Interrupt status, enable and clear
   // ------------------------------------------------------------------
   // Bit 0 block end, bit 1 stop by software clear; set wins over clear
   // Stop counts only with a word in flight; disarming a waiting
   // channel is not a stop and must not raise a stale interrupt.
   wire       stop_ev = sw_clear && in_move;
   wire [1:0] ev      = {stop_ev, blk_end};
   wire [1:0] clr_m   = wr_clr ? bus.writedata[1:0] : 2'b00;
   wire [1:0] sts_d   = ev | (sts_q & ~clr_m);
   wire [1:0] ien_d   = {2{ctrl_d.ie}};

   // Readback
   wire [31:0] rd_ctrl = {8'h00, ctrl_q.en, ctrl_q.ie, ctrl_q.mode,
                          19'h00000};
   wire [31:0] rd_cnt  = {16'h0000, 16'(cnt_q)};
   wire [31:0] rd_sts  = {16'(orig_q), 7'h00, mv_busy, 6'h00, sts_q};
   wire        sel_ctrl = (bus.address == `DCXM_OFF_CTRL);
   wire        sel_cnt  = (bus.address == `DCXM_OFF_COUNT);
   wire        sel_sts  = (bus.address == `DCXM_OFF_STATUS);
   wire [31:0] rd_mux   =
        sel_ctrl ? rd_ctrl
      : sel_cnt  ? rd_cnt
      : sel_sts  ? rd_sts
      : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sts_q           <= 2'b00;
         irq             <= 1'b0;
         avs_readdata    <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         word_move       <= 1'b0;
         block_end       <= 1'b0;
      end else begin
         sts_q           <= sts_d;
         irq             <= |(sts_d & ien_d);
         avs_readdata    <= (bus.read && acc) ? rd_mux : avs_readdata;
         avs_waitrequest <= !acc;
         word_move       <= mv_done;
         block_end       <= blk_end;
      end
   end
endmodule // dcxm_transfer_modes

// File: verif/dcxm_transfer_modes_props.sv
// Checker for the transfer-mode block's bus and event ports.
// Assumes a bind from the bench onto the top module.
`timescale 1ns/1ps
module dcxm_transfer_modes_props (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq,
   input wire logic        word_move,
   input wire logic        block_end
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire req = avs_read | avs_write;
   // Clear of both status bits with no block end racing it
   sequence s_clr;
      !block_end && avs_write && !avs_waitrequest && avs_address == 4'hC
         && avs_writedata[1:0] == 2'h3 ##1 !block_end;
   endsequence
   a_one_wait: assert property ($rose(req) |=> !avs_waitrequest)
      else $error("no answer after one wait state");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low two cycles");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_held: assert property (!avs_read && !$past(avs_read)
      |-> $stable(avs_readdata)) else $error("read data changed");
   a_move_pulse: assert property (word_move |=> !word_move)
      else $error("word pulse too long");
   a_end_pulse: assert property (block_end |=> !block_end)
      else $error("block end pulse too long");
   a_end_after_move: assert property ($rose(block_end) |->
      word_move || $past(word_move) || $past(word_move, 2))
      else $error("block end without a stored word");
   a_irq_clears: assert property (s_clr |=> ##[0:1] !irq)
      else $error("interrupt stays after clear");
endmodule // dcxm_transfer_modes_props

// File: verif/dcxm_req_model.sv
// Peripheral request source: one or two request pulses per fire.
// Assumes fire is a one-cycle pulse from the bench while idle.
`timescale 1ns/1ps
module dcxm_req_model (
   input  wire logic       clock,
   input  wire logic       fire,
   input  wire logic       dbl,
   input  wire logic [3:0] hold,
   output logic            dma_req,
   output logic            busy
);
   logic [5:0] t_q = 6'h00;
   logic [3:0] h_q = 4'h1;
   logic       dbl_q = 1'b0;
   // Hold sets the speed; a double gives a second edge mid-service
   always @(posedge clock) begin
      if (fire) begin
         t_q   <= 6'h01;
         h_q   <= hold;
         dbl_q <= dbl;
      end else if (t_q != 6'h00) begin
         t_q <= (int'(t_q) == (dbl_q ? 4 : 2) * h_q) ? 6'h00 : t_q + 6'h01;
      end
   end
   assign busy    = t_q != 6'h00;
   assign dma_req = busy && (((t_q - 6'h01) / h_q) % 2 == 0);
endmodule // dcxm_req_model

// File: verif/test_dcxm_transfer_modes.sv
// Self-checking bench for the transfer-mode block.
// Assumes the checker and request model compile before it.
`timescale 1ns/1ps
module test_dcxm_transfer_modes;
   logic        clock;
   logic        rst_n;
   logic        fire;
   logic        dbl;
   logic        dma_req;
   logic        busy;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        word_move;
   logic        block_end;
   logic [31:0] q;
   int          err_count = 0;
   int          n_checks = 0;
   int          n_w = 0;
   int          n_e = 0;
   int          cyc = 0;
   // Nibbles: mode, count, requests, words, ends, enable after, double
   localparam logic [27:0] TBL [9] = '{28'h0212100, 28'h1222100,
      28'h1212101, 28'h2828100, 28'h3303100, 28'h4224210, 28'h5233110,
      28'h6210010, 28'h7210010};

   dcxm_transfer_modes #(.LINE_LEN(4)) uut (.clock(clock), .rst_n(rst_n),
      .dma_req(dma_req), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .word_move(word_move), .block_end(block_end));
   dcxm_req_model peer (.clock(clock), .fire(fire), .dbl(dbl),
      .hold(dbl ? 4'h2 : 4'h5), .dma_req(dma_req), .busy(busy));

   // ----------------
   // Tasks
   // ----------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic acc(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic settle();
      int quiet;
      quiet = 0;
      while (quiet < 16) begin
         @(posedge clock);
         quiet = (word_move === 1'b1 || busy) ? 0 : quiet + 1;
      end
   endtask
   task automatic req(input logic d);
      dbl  <= d;
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      settle();
   endtask
   task automatic run(input logic [27:0] t);
      logic [2:0] m;
      int         c;
      m   = t[26:24];
      c   = int'(t[23:20]);
      n_w = 0;
      n_e = 0;
      acc(1'b1, 4'h4, 32'(c), q);
      acc(1'b1, 4'h0, {8'h0, 2'h3, m, 19'h0}, q);
      settle();
      repeat (t[19:16]) req(t[0]);
      chk(32'(n_w), 32'(t[15:12]));
      chk(32'(n_e), 32'(t[11:8]));
      acc(1'b0, 4'h0, 32'h0, q);
      chk(q, {8'h0, t[4], 1'b1, m, 19'h0});
      acc(1'b0, 4'h4, 32'h0, q);
      chk(q, 32'(c - int'(t[15:12]) % c));
      if (m != 3'h4 && m != 3'h5) chk(32'(irq), 32'(t[9:8] != 2'h0));
      acc(1'b1, 4'hC, 32'h3, q);
      acc(1'b0, 4'h8, 32'h0, q);
      chk({q[31:16], 7'h0, q[8], 7'h0, q[0]}, {16'(c), 16'h0});
      chk(32'(irq), 32'h0);
      acc(1'b1, 4'h0, 32'h0, q);
   endtask

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (word_move === 1'b1) n_w++;
      if (block_end === 1'b1) n_e++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      rst_n = 1'b0;
      fire = 1'b0;
      dbl = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      acc(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h0);
      acc(1'b1, 4'h2, 32'hFFFF_FFFF, q);
      acc(1'b0, 4'h2, 32'h0, q);
      chk(q, 32'h0);
      foreach (TBL[i]) run(TBL[i]);
      // Software stop in mid-block: counter must match stored words
      n_w = 0;
      acc(1'b1, 4'h4, 32'h8, q);
      acc(1'b1, 4'h0, 32'h0098_0000, q);
      while (n_w == 0) @(posedge clock);
      acc(1'b1, 4'h0, 32'h0, q);
      settle();
      chk(32'(n_w < 8), 32'h1);
      acc(1'b0, 4'h4, 32'h0, q);
      chk(q, 32'(8 - n_w));
      acc(1'b0, 4'h8, 32'h0, q);
      chk(32'(q[1]), 32'h1);
      end_sim();
   end
endmodule // test_dcxm_transfer_modes

bind dcxm_transfer_modes dcxm_transfer_modes_props u_props (
   .clock(clock), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq),
   .word_move(word_move), .block_end(block_end));
